// file: hw/ssl_cfg_port.sv
// Configuration port: strap latch, bus slave, shared registers, EEPROM load
`timescale 1ns/100ps
module ssl_cfg_port #(
    parameter logic [2:0] REV_CODE = 3'h1,   // Arbitrary value
    parameter logic [4:0] VARIANT  = 5'h0_5, // Arbitrary value
    parameter int         QTR      = ssl_pkg::QTR_CYC,
    parameter int         NBYTES   = 4
) (
    input  wire logic       clk,
    input  wire logic       nrst,
    input  wire logic       serial_bus_clock_line_in,
    output logic            serial_bus_clock_line_out,
    output logic            serial_bus_clock_line_oe_n,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe_n,
    input  wire logic       config_mode_select,
    input  wire logic       load_request_n,
    output logic            load_done_n,
    input  wire logic [3:0] strap_lock_in,
    output logic      [3:0] strap_lock_out,
    output logic      [3:0] strap_lock_oe_n,
    input  wire logic [3:0] chan_lock,
    input  wire logic [3:0] chan_irq
);
    typedef enum logic [2:0] {
        S_IDLE, S_ADDR, S_ACK, S_REG, S_WR, S_RD, S_RACK
    } ssl_sl_t;

    ssl_pkg::ssl_bus_t    bus_s, bus_q, ld_low;
    ssl_pkg::ssl_cfg_wr_t ld_cfg;
    logic [3:0] strap_s;
    logic       mode_s, req_s;
    logic       ld_busy, ld_done;

    ssl_sync2 #(.W(2)) u_bus_sync (
        .clk  (clk),
        .nrst (nrst),
        .d    ({serial_bus_clock_line_in, sda_in}),
        .q    (bus_s)
    );

    ssl_sync2 #(.W(6)) u_pin_sync (
        .clk  (clk),
        .nrst (nrst),
        .d    ({strap_lock_in, config_mode_select, load_request_n}),
        .q    ({strap_s, mode_s, req_s})
    );

    // Power-up capture of straps and mode pins
    logic [1:0] pu_cnt, next_pu_cnt;
    logic       latched, next_latched;
    logic [3:0] strap, next_strap;
    logic       master_mode, next_master_mode;
    logic       test_addr, next_test_addr;
    logic [6:0] my_addr;

    always_comb begin
        next_pu_cnt = pu_cnt; next_latched = latched; next_strap = strap;
        next_master_mode = master_mode; next_test_addr = test_addr;
        if (!latched) begin
            next_pu_cnt = pu_cnt + 2'h1;
            if (pu_cnt == ssl_pkg::PU_LAST) begin
                next_latched     = 1'b1;
                next_strap       = strap_s;
                next_master_mode = !mode_s;
                next_test_addr   = mode_s && req_s;
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pu_cnt <= '0; latched <= 1'b0; strap <= '0;
            master_mode <= 1'b0; test_addr <= 1'b0;
        end else begin
            pu_cnt <= next_pu_cnt; latched <= next_latched;
            strap <= next_strap; master_mode <= next_master_mode;
            test_addr <= next_test_addr;
        end
    end

    // Test address overrides the straps so a lone part is always reachable
    assign my_addr = test_addr ? ssl_pkg::TEST_ADDR
                   : 7'(ssl_pkg::ADDR_BASE + {3'h0, strap});

    // Shared registers and load control
    logic [2:0] ctrl, next_ctrl;   // {shared reset, master reset, imm load}
    logic       mdis, next_mdis;
    logic [3:0] flags, next_flags;
    logic [3:0] diag, next_diag;
    logic       done, next_done;
    logic       mrst_q;
    logic       wr_en;
    logic [7:0] wr_adr, wr_dat;
    logic       sl_wr;
    logic [7:0] ptr, sh;
    logic       start;
    logic [7:0] rdata;

    assign wr_en  = sl_wr || ld_cfg.valid;
    assign wr_adr = ld_cfg.valid ? ld_cfg.idx  : ptr;
    assign wr_dat = ld_cfg.valid ? ld_cfg.data : sh;

    localparam int CI = ssl_pkg::CTRL_IMM;
    localparam int CM = ssl_pkg::CTRL_MRST;
    localparam int CS = ssl_pkg::CTRL_SRST;

    // Disable is checked only before a load begins; a running load finishes
    assign start = !done && !ld_busy && !mdis
        && ((master_mode && !req_s && latched)
            || ctrl[CI - CI]);

    always_comb begin
        next_ctrl = ctrl; next_mdis = mdis; next_diag = diag;
        next_flags = flags; next_done = done;
        if (ctrl[CS - CI]) begin
            next_ctrl  = ssl_pkg::CTRL_RESET;
            next_mdis  = 1'b0;
            next_diag  = ssl_pkg::DIAG_RESET;
            next_flags = '0;
        end else if (wr_en) begin
            case (wr_adr)
                ssl_pkg::REG_CTRL: next_ctrl = wr_dat[CS:CI];
                ssl_pkg::REG_STAT: begin
                    next_mdis  = wr_dat[ssl_pkg::STAT_MDIS];
                    next_flags = flags & ~wr_dat[3:0];
                end
                ssl_pkg::REG_DIAG: next_diag = wr_dat[3:0];
                default: ;
            endcase
        end
        next_flags = next_flags | chan_irq;
        if (ctrl[CM - CI] && !mrst_q && !ld_busy)
            next_done = 1'b0;
        if (ld_done)
            next_done = 1'b1;
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ctrl <= ssl_pkg::CTRL_RESET; mdis <= 1'b0; flags <= '0;
            diag <= ssl_pkg::DIAG_RESET; done <= 1'b0; mrst_q <= 1'b0;
        end else begin
            ctrl <= next_ctrl; mdis <= next_mdis; flags <= next_flags;
            diag <= next_diag; done <= next_done;
            mrst_q <= ctrl[CM - CI];
        end
    end

    always_comb begin
        case (ptr)
            ssl_pkg::REG_STRAP:
                rdata = {(diag == ssl_pkg::DIAG_KEY) ? strap : 4'h0,
                         4'h0};
            ssl_pkg::REG_IDENT: rdata = {REV_CODE, VARIANT};
            ssl_pkg::REG_CTRL:  rdata = {1'b0, ctrl, 4'h0};
            ssl_pkg::REG_STAT:
                rdata = {mdis, 2'h0, done, flags};
            ssl_pkg::REG_DIAG:  rdata = {4'h0, diag};
            default:            rdata = 8'h00;
        endcase
    end

    ssl_eeprom_loader #(.QTR(QTR), .NBYTES(NBYTES)) u_loader (
        .clk       (clk),
        .nrst      (nrst),
        .start     (start),
        .sda_in    (bus_s.sda),
        .drive_low (ld_low),
        .busy      (ld_busy),
        .done      (ld_done),
        .cfg       (ld_cfg)
    );

    // Byte-data slave on the synchronised bus lines
    ssl_sl_t    st, next_st, nxt, next_nxt;
    logic [3:0] cnt, next_cnt;
    logic [7:0] next_ptr, next_sh;
    logic       drv, next_drv;
    logic       next_sl_wr;
    logic       rise, fall, bstart, bstop;

    assign rise   = bus_s.scl && !bus_q.scl;
    assign fall   = !bus_s.scl && bus_q.scl;
    assign bstart = bus_s.scl && bus_q.scl && bus_q.sda && !bus_s.sda;
    assign bstop  = bus_s.scl && bus_q.scl && !bus_q.sda && bus_s.sda;

    always_comb begin
        next_st = st; next_nxt = nxt; next_cnt = cnt; next_ptr = ptr;
        next_sh = sh; next_drv = drv; next_sl_wr = 1'b0;
        if (!latched || ld_busy) begin
            next_st = S_IDLE;
            next_drv = 1'b0;
        end else if (bstart) begin
            next_st = S_ADDR;
            next_cnt = '0;
            next_drv = 1'b0;
        end else if (bstop) begin
            next_st = S_IDLE;
            next_drv = 1'b0;
        end else begin
            case (st)
                S_ADDR, S_REG, S_WR: begin
                    if (rise) begin
                        next_sh  = {sh[6:0], bus_s.sda};
                        next_cnt = cnt + 4'h1;
                    end else if (fall && cnt == ssl_pkg::BITS_BYTE) begin
                        next_drv = 1'b1;
                        next_st  = S_ACK;
                        if (st == S_ADDR) begin
                            if (sh[7:1] != my_addr) begin
                                next_st  = S_IDLE;
                                next_drv = 1'b0;
                            end
                            next_nxt = sh[0] ? S_RD : S_REG;
                        end else if (st == S_REG) begin
                            next_ptr = sh;
                            next_nxt = S_WR;
                        end else begin
                            next_sl_wr = 1'b1;
                            next_nxt = S_WR;
                        end
                    end
                end
                S_ACK: begin
                    if (fall) begin
                        next_cnt = '0;
                        next_st  = nxt;
                        next_drv = 1'b0;
                        if (nxt == S_RD) begin
                            next_sh  = rdata;
                            next_drv = !rdata[7];
                        end
                    end
                end
                S_RD: begin
                    if (rise)
                        next_cnt = cnt + 4'h1;
                    else if (fall) begin
                        next_sh  = {sh[6:0], 1'b0};
                        next_drv = !sh[6];
                        if (cnt == ssl_pkg::BITS_BYTE) begin
                            next_drv = 1'b0;
                            next_st  = S_RACK;
                        end
                    end
                end
                S_RACK: if (rise) next_st = S_IDLE;
                default: next_st = S_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st <= S_IDLE; nxt <= S_IDLE; cnt <= '0; ptr <= '0;
            sh <= '0; drv <= 1'b0; sl_wr <= 1'b0; bus_q <= '1;
        end else begin
            st <= next_st; nxt <= next_nxt; cnt <= next_cnt;
            ptr <= next_ptr; sh <= next_sh; drv <= next_drv;
            sl_wr <= next_sl_wr; bus_q <= bus_s;
        end
    end

    // Pin drivers, all registered
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            serial_bus_clock_line_out  <= 1'b0;
            serial_bus_clock_line_oe_n <= 1'b1;
            sda_out         <= 1'b0;
            sda_oe_n        <= 1'b1;
            load_done_n     <= 1'b1;
            strap_lock_out  <= '0;
            strap_lock_oe_n <= '1;
        end else begin
            serial_bus_clock_line_out  <= 1'b0;
            serial_bus_clock_line_oe_n <= !ld_low.scl;
            sda_out         <= 1'b0;
            sda_oe_n        <= !(drv || ld_low.sda);
            load_done_n     <= !done;
            strap_lock_out  <= latched ? chan_lock : 4'h0;
            strap_lock_oe_n <= {4{!latched}};
        end
    end
endmodule

// file: include/ssl_pkg.sv
// Constants, field layout and carrier types of the configuration port
package ssl_pkg;
    localparam int CLK_NS   = 50;
    localparam int BIT_NS   = 10000;
    localparam int QTR_CYC  = BIT_NS / (4 * CLK_NS);

    localparam logic [7:0] REG_STRAP = 8'h00;
    localparam logic [7:0] REG_IDENT = 8'h01;
    localparam logic [7:0] REG_CTRL  = 8'h04;
    localparam logic [7:0] REG_STAT  = 8'h05;
    localparam logic [7:0] REG_DIAG  = 8'h06;

    localparam int CTRL_IMM  = 4;
    localparam int CTRL_MRST = 5;
    localparam int CTRL_SRST = 6;
    localparam int STAT_DONE = 4;
    localparam int STAT_MDIS = 7;

    localparam logic [3:0] DIAG_KEY   = 4'h0_a;
    localparam logic [6:0] ADDR_BASE  = 7'h18;
    localparam logic [6:0] TEST_ADDR  = 7'h18;
    localparam logic [2:0] CTRL_RESET = 3'h0;
    localparam logic [3:0] DIAG_RESET = 4'h0;
    localparam logic [1:0] PU_LAST    = 2'h3;
    localparam logic [3:0] BITS_BYTE  = 4'h8;

    typedef struct packed {
        logic scl;
        logic sda;
    } ssl_bus_t;

    typedef struct packed {
        logic       valid;
        logic [7:0] idx;
        logic [7:0] data;
    } ssl_cfg_wr_t;
endpackage

// file: hw/ssl_sync2.sv
// Two-flop synchroniser for pin inputs
`timescale 1ns/100ps
module ssl_sync2 #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         nrst,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta;
    logic [W-1:0] next_meta;
    logic [W-1:0] next_q;

    always_comb begin
        next_meta = d;
        next_q    = meta;
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            meta <= '0;
            q    <= '0;
        end else begin
            meta <= next_meta;
            q    <= next_q;
        end
    end
endmodule

// file: hw/ssl_eeprom_loader.sv
// Bus master that reads configuration bytes from a serial EEPROM
`timescale 1ns/100ps
module ssl_eeprom_loader #(
    parameter int         QTR    = ssl_pkg::QTR_CYC,
    parameter int         NBYTES = 4,
    parameter logic [6:0] EE_DEV = 7'h50
) (
    input  wire logic              clk,
    input  wire logic              nrst,
    input  wire logic              start,
    input  wire logic              sda_in,
    output ssl_pkg::ssl_bus_t      drive_low,
    output logic                   busy,
    output logic                   done,
    output ssl_pkg::ssl_cfg_wr_t   cfg
);
    typedef enum logic [0:0] {LD_IDLE, LD_RUN} ssl_ld_t;
    localparam logic [7:0] SEQ_RX   = 8'h05;
    localparam logic [7:0] SEQ_STOP = 8'(5 + NBYTES);

    ssl_ld_t     st, next_st;
    logic [15:0] div, next_div;
    logic [1:0]  ph, next_ph;
    logic [3:0]  bitn, next_bitn;
    logic [7:0]  seq, next_seq;
    logic [7:0]  sh, next_sh;
    ssl_pkg::ssl_bus_t    next_drive;
    ssl_pkg::ssl_cfg_wr_t next_cfg;
    logic        next_done;
    logic        tick;
    logic        is_start, is_rx;
    logic [7:0]  tx;

    assign tick     = (div == 16'(QTR - 1));
    assign is_start = (seq == 8'h00) || (seq == 8'h03);
    assign is_rx    = (seq >= SEQ_RX) && (seq < SEQ_STOP);

    always_comb begin
        case (seq)
            8'h01:   tx = {EE_DEV, 1'b0};
            8'h04:   tx = {EE_DEV, 1'b1};
            default: tx = 8'h00;
        endcase
    end

    always_comb begin
        next_st = st; next_div = div; next_ph = ph; next_bitn = bitn;
        next_seq = seq; next_sh = sh; next_drive = drive_low;
        next_cfg = '0; next_done = 1'b0;
        case (st)
            LD_IDLE: begin
                next_drive = '0;
                next_div = '0; next_ph = '0; next_bitn = '0; next_seq = '0;
                if (start)
                    next_st = LD_RUN;
            end
            LD_RUN: begin
                next_div = tick ? 16'h0 : div + 16'h1;
                if (tick) begin
                    next_ph = ph + 2'h1;
                    if (is_start) begin
                        case (ph)
                            2'h0: next_drive.sda = 1'b0;
                            2'h1: next_drive.scl = 1'b0;
                            2'h2: next_drive.sda = 1'b1;
                            default: begin
                                next_drive.scl = 1'b1;
                                next_seq = seq + 8'h1;
                            end
                        endcase
                    end else if (seq == SEQ_STOP) begin
                        case (ph)
                            2'h0: next_drive.sda = 1'b1;
                            2'h1: next_drive.scl = 1'b0;
                            2'h2: next_drive.sda = 1'b0;
                            default: begin
                                next_st   = LD_IDLE;
                                next_done = 1'b1;
                            end
                        endcase
                    end else begin
                        case (ph)
                            2'h0: begin
                                if (bitn == ssl_pkg::BITS_BYTE)
                                    next_drive.sda = is_rx
                                        && (seq != SEQ_STOP - 8'h1);
                                else
                                    next_drive.sda = !is_rx
                                        && !tx[3'(7 - bitn)];
                            end
                            2'h1: next_drive.scl = 1'b0;
                            2'h2: begin
                                if (is_rx && bitn < ssl_pkg::BITS_BYTE)
                                    next_sh = {sh[6:0], sda_in};
                            end
                            default: begin
                                next_drive.scl = 1'b1;
                                next_bitn = bitn + 4'h1;
                                if (bitn == ssl_pkg::BITS_BYTE) begin
                                    next_bitn = '0;
                                    next_seq  = seq + 8'h1;
                                    next_cfg  = {is_rx, seq - SEQ_RX, sh};
                                end
                            end
                        endcase
                    end
                end
            end
            default: next_st = LD_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st <= LD_IDLE; div <= '0; ph <= '0; bitn <= '0; seq <= '0;
            sh <= '0; drive_low <= '0; cfg <= '0; done <= 1'b0;
        end else begin
            st <= next_st; div <= next_div; ph <= next_ph;
            bitn <= next_bitn; seq <= next_seq; sh <= next_sh;
            drive_low <= next_drive; cfg <= next_cfg; done <= next_done;
        end
    end

    assign busy = (st == LD_RUN);
endmodule

// file: bench/ssl_cfg_port_props.sv
// Port-level assertions of the configuration port
`timescale 1ns/100ps
module ssl_cfg_port_props (
    input wire logic       clk,
    input wire logic       nrst,
    input wire logic       serial_bus_clock_line_out,
    input wire logic       serial_bus_clock_line_oe_n,
    input wire logic       sda_out,
    input wire logic       sda_oe_n,
    input wire logic       config_mode_select,
    input wire logic       load_request_n,
    input wire logic       load_done_n,
    input wire logic [3:0] strap_lock_out,
    input wire logic [3:0] strap_lock_oe_n,
    input wire logic [3:0] chan_lock
);
    logic [3:0] age;
    logic [3:0] next_age;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    always_comb next_age = (age == 4'hf) ? age : age + 4'h1;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) age <= 4'h0;
        else age <= next_age;
    end
    chk_pins_open: assert property (!serial_bus_clock_line_out && !sda_out)
        else $error("bus pin driven high");
    chk_latch_time: assert property (age >= 4'h8 |-> strap_lock_oe_n == 4'h0)
        else $error("straps not latched in time");
    chk_addr_held: assert property (strap_lock_oe_n == 4'h0 |=> strap_lock_oe_n == 4'h0)
        else $error("latched address dropped");
    chk_quiet_early: assert property (strap_lock_oe_n != 4'h0 |-> serial_bus_clock_line_oe_n && sda_oe_n)
        else $error("bus driven before latch");
    chk_lock_idle: assert property (strap_lock_oe_n != 4'h0 |-> strap_lock_out == 4'h0)
        else $error("lock driven before latch");
    chk_lock_follow: assert property (strap_lock_oe_n == 4'h0 && $past(strap_lock_oe_n) == 4'h0 |-> strap_lock_out == $past(chan_lock))
        else $error("lock pin not following lock");
    chk_done_release: assert property ($fell(load_done_n) |-> serial_bus_clock_line_oe_n && sda_oe_n)
        else $error("bus held after load");
    chk_master_start: assert property ($fell(strap_lock_oe_n[0]) && !config_mode_select && !load_request_n |-> ##[0:60] !serial_bus_clock_line_oe_n)
        else $error("master load did not start");
endmodule
bind ssl_cfg_port ssl_cfg_port_props i_ssl_cfg_port_props (.clk, .nrst,
    .serial_bus_clock_line_out, .serial_bus_clock_line_oe_n, .sda_out,
    .sda_oe_n, .config_mode_select, .load_request_n, .load_done_n,
    .strap_lock_out, .strap_lock_oe_n, .chan_lock);

// file: bench/ssl_ee_model.sv
// Behavioural serial configuration memory on the open-drain bus
`timescale 1ns/100ps
module ssl_ee_model #(
    parameter logic [6:0] DEV = 7'h50,
    parameter logic [7:0] PAT = 8'h0a
) (
    input  wire logic scl,
    input  wire logic sda,
    output logic      sda_drv
);
    int         n = 0;
    logic [7:0] sh = 8'h00;
    logic       first = 1'b1;
    logic       act = 1'b0;
    logic       rd = 1'b0;
    logic       dph = 1'b0;
    initial sda_drv = 1'b1;
    // Start and stop both resynchronise; model only ever pulls low
    always @(sda) if (scl) begin
        n = 0;
        first = 1'b1;
        act = 1'b0;
        rd = 1'b0;
        dph = 1'b0;
    end
    always @(posedge scl) begin
        if (n < 8) sh = {sh[6:0], sda};
        // A master NACK ends the read so the line is free for the stop
        if (n == 8 && dph && sda) act = 1'b0;
        n = n + 1;
    end
    always @(negedge scl) begin
        if (n == 8) begin
            if (first) begin
                act = (sh[7:1] == DEV);
                rd = sh[0];
                first = 1'b0;
            end
            sda_drv = !(act && !dph);
        end else if (n == 9) begin
            n = 0;
            dph = rd;
            sda_drv = !(act && rd) | PAT[7];
        end else if (act && dph) sda_drv = PAT[7 - n];
    end
endmodule

// file: bench/ssl_cfg_port_tb_top.sv
// Self-checking bench of the configuration port
`timescale 1ns/100ps
module ssl_cfg_port_tb_top;
    localparam logic [7:0] IDENT = {3'h1, 5'h0_5};
    logic        clk = 1'b0, nrst = 1'b0, scl_h = 1'b1, sda_h = 1'b1;
    logic        mode = 1'b1, req_n = 1'b0, sda_s = 1'b1, ak;
    logic [3:0]  strap = 4'h0, lock = 4'h0, irq = 4'h0, fl, lk_o, lk_oe_n;
    logic [31:0] rs = 32'h0000_fbfb;
    logic [7:0]  v;
    logic [6:0]  a7;
    logic        scl_o, scl_oe_n, sda_o, sda_oe_n, ee_d, done_n;
    int          n_fail = 0;
    int          checked = 0;
    wire         scl = scl_h & (scl_oe_n | scl_o);
    wire         sda = sda_h & (sda_oe_n | sda_o) & ee_d;
    wire  [3:0]  lk = (strap & lk_oe_n) | (lk_o & ~lk_oe_n);
    ssl_cfg_port #(.REV_CODE(3'h1), .VARIANT(5'h0_5), .QTR(2), .NBYTES(7))
    i_ssl_cfg_port (.clk(clk), .nrst(nrst), .serial_bus_clock_line_in(scl),
        .serial_bus_clock_line_out(scl_o), .serial_bus_clock_line_oe_n(scl_oe_n),
        .sda_in(sda), .sda_out(sda_o), .sda_oe_n(sda_oe_n),
        .config_mode_select(mode), .load_request_n(req_n),
        .load_done_n(done_n), .strap_lock_in(lk), .strap_lock_out(lk_o),
        .strap_lock_oe_n(lk_oe_n), .chan_lock(lock), .chan_irq(irq));
    ssl_ee_model i_ssl_ee_model (.scl(scl), .sda(sda), .sda_drv(ee_d));
    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    initial forever #25 clk = ~clk;
    always @(negedge clk) sda_s <= sda;
    always @(posedge clk) begin
        rs <= xs(rs);
        lock <= rs[3:0];
    end
    task automatic results;
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic cmp(input string nm, input logic [7:0] e, input logic [7:0] s);
        checked++;
        if (s !== e) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", nm, e, s);
        end
    endtask
    // Each bus phase lasts 10 cycles, beyond the slave's pipeline delay
    task automatic hp(input logic c, input logic d);
        scl_h <= c;
        sda_h <= d;
        repeat (10) @(posedge clk);
    endtask
    task automatic go(input logic s);
        hp(1'b1, !s);
        hp(1'b1, s);
        hp(1'b1, s);
    endtask
    task automatic xb(input logic [7:0] b, input logic m, output logic a,
                      output logic [7:0] r);
        for (int i = 7; i >= 0; i--) begin
            hp(1'b0, b[i]);
            hp(1'b1, b[i]);
            r[i] = sda_s;
            hp(1'b0, b[i]);
        end
        hp(1'b0, m);
        hp(1'b1, m);
        a = sda_s;
        hp(1'b0, m);
    endtask
    task automatic acc(input logic [6:0] ad, input logic [7:0] off,
                       input logic w, input logic [7:0] d, output logic a,
                       output logic [7:0] r);
        logic       x;
        logic [7:0] y;
        go(1'b0);
        xb({ad, 1'b0}, 1'b1, a, y);
        xb(off, 1'b1, x, y);
        if (w) xb(d, 1'b1, x, y);
        else begin
            go(1'b0);
            xb({ad, 1'b1}, 1'b1, x, y);
            xb(8'hff, 1'b1, x, r);
        end
        hp(1'b0, 1'b0);
        go(1'b1);
    endtask
    task automatic wr(input logic [6:0] ad, input logic [7:0] off, input logic [7:0] d);
        acc(ad, off, 1'b1, d, ak, v);
        cmp("write ack", 8'h00, {7'h0, ak});
    endtask
    task automatic rd(input logic [6:0] ad, input logic [7:0] off,
                      input logic [7:0] e, input string nm);
        acc(ad, off, 1'b0, 8'h00, ak, v);
        cmp(nm, e, v);
    endtask
    task automatic rst(input logic m, input logic q);
        nrst <= 1'b0;
        mode <= m;
        req_n <= q;
        strap <= rs[7:4];
        repeat (16) @(posedge clk);
        nrst <= 1'b1;
        repeat (10) @(posedge clk);
        a7 = 7'h18 + {3'h0, strap};
    endtask
    task automatic quiet;
        logic hit;
        hit = 1'b0;
        repeat (300) begin
            @(posedge clk);
            if (scl_oe_n !== 1'b1) hit = 1'b1;
        end
        cmp("clock left released", 8'h00, {7'h0, hit});
    endtask
    // Load is over once the clock line has stayed released for 200 cycles
    task automatic wload;
        int k;
        int idle;
        k = 0;
        idle = 0;
        while (scl_oe_n !== 1'b0 && k < 5000) begin
            @(posedge clk);
            k++;
        end
        while (idle < 200 && k < 20000) begin
            @(posedge clk);
            k++;
            idle = (scl_oe_n === 1'b1) ? idle + 1 : 0;
        end
        if (k >= 5000) begin
            n_fail++;
            $display("mismatch load timing expected short seen %0d", k);
            results();
        end
    endtask
    initial begin
        rst(1'b1, 1'b0);
        wr(a7, 8'h06, 8'h0a);
        rd(a7, 8'h00, {strap, 4'h0}, "strap observe");
        rd(a7, 8'h01, IDENT, "identity");
        acc(a7 ^ 7'h01, 8'h01, 1'b0, 8'h00, ak, v);
        cmp("foreign address ack", 8'h01, {7'h0, ak});
        fl = rs[3:0] | 4'h1;
        irq <= fl;
        @(posedge clk);
        irq <= 4'h0;
        rd(a7, 8'h05, {4'h0, fl}, "channel flags");
        wr(a7, 8'h05, 8'h0f);
        rd(a7, 8'h05, 8'h00, "flags cleared");
        wr(a7, 8'h04, 8'h40);
        rd(a7, 8'h06, 8'h00, "diag after reset");
        rd(a7, 8'h04, 8'h00, "control after reset");
        wr(a7, 8'h04, 8'h10);
        wload;
        cmp("load done pin", 8'h00, {7'h0, done_n});
        rd(a7, 8'h05, 8'h10, "load status");
        wr(a7, 8'h04, 8'h10);
        quiet;
        rst(1'b1, 1'b1);
        rd(7'h18, 8'h01, IDENT, "test address");
        rst(1'b0, 1'b0);
        wload;
        rd(a7, 8'h05, 8'h10, "master load status");
        rd(a7, 8'h00, {strap, 4'h0}, "loaded diag");
        wr(a7, 8'h05, 8'h80);
        wr(a7, 8'h04, 8'h20);
        wr(a7, 8'h04, 8'h00);
        quiet;
        rd(a7, 8'h05, 8'h80, "re-armed status");
        req_n <= 1'b1;
        wr(a7, 8'h05, 8'h00);
        req_n <= 1'b0;
        wload;
        rd(a7, 8'h05, 8'h10, "reload status");
        results();
    end
endmodule
